//--- rtl/mcuor_pkg.sv
// Purpose: constants for the operational register bank of the core
// Assumes: 8-bit data space, addresses 00h..0Ah handled here
// Notes: offsets are data addresses on the core's internal register port
package mcuor_pkg;
  // register addresses
  localparam logic [5:0] ADDR_INDIRECT = 6'h00;
  localparam logic [5:0] ADDR_TIMER = 6'h01;
  localparam logic [5:0] ADDR_PC_LOW = 6'h02;
  localparam logic [5:0] ADDR_STATUS = 6'h03;
  localparam logic [5:0] ADDR_RAM_PTR = 6'h04;
  localparam logic [5:0] ADDR_PORT5 = 6'h05;
  localparam logic [5:0] ADDR_PORT6 = 6'h06;
  localparam logic [5:0] ADDR_PORT7 = 6'h07;
  localparam logic [5:0] ADDR_PORT8 = 6'h08;
  localparam logic [5:0] ADDR_LCD_CTRL = 6'h09;
  localparam logic [5:0] ADDR_LCD_PTR = 6'h0A;
  // status field positions
  localparam int ST_PAGE_HI = 6;
  localparam int ST_PAGE_LO = 5;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_PWRDN = 3;
  localparam int ST_ZERO = 2;
  localparam int ST_NIBBLE = 1;
  localparam int ST_CARRY = 0;
  // lcd control field positions
  localparam int LCD_BIAS = 7;
  localparam int LCD_DUTY_HI = 6;
  localparam int LCD_DUTY_LO = 5;
  localparam int LCD_EN = 4;
  localparam int LCD_WAVE = 2;
  // reset values and masks
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] LCD_PTR_MASK = 8'h1F;
  localparam logic [7:0] PORT5_MASK = 8'hF1;
  localparam logic [7:0] STATUS_MASK = 8'h7F;
  // program counter operations
  typedef enum logic [2:0] {
    MCUOR_PC_STEP, MCUOR_PC_JUMP, MCUOR_PC_CALL, MCUOR_PC_RET,
    MCUOR_PC_HOLD
  } mcuor_pcop_e;
endpackage

//--- rtl/mcuor_regs.sv
// Purpose: operational registers 00h..0Ah of an 8-bit core
// Assumes: one write or read per cycle from the core; pins pre-qualified
// Notes: page field lands in pc on jumps, calls and moves to pc; steps, returns and adds leave it out
//
// Summary of operation
// - address 00h redirects through ram pointer
// - timer counts pin edges or cycles
// - 13-bit pc cleared on reset
// - jump loads low ten pc bits
// - call loads ten bits, pushes next
// - return reloads whole pc from stack
// - add to pc carries upward
// - move to pc replaces low eight
// - page bits copied into pc 11:10
// - status bits 6:5 pick program page
// - timeout flag set power/sleep/clear, cleared watchdog
// - power-down flag set clear-cmd, cleared sleep
// - flag pairs encode wake causes
// - status bits 2..0 zero, nibble, carry
// - ram pointer bits 7:6 read-write, unused
// - ram pointer bits 5:0 indirect address
// - port5 data high nibble, bit0 page
// - ports 6..8 hold 8-bit data
// - lcd duty bits 6:5
// - lcd disabled drives outputs to ground
// - frame divisor from duty and rate code
`timescale 1ns/10ps
`default_nettype none
module mcuor_regs #(
  parameter int STACK_DEPTH = 8
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // register access port
  input wire logic [5:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic [5:0] o_mem_addr,
  input wire logic [7:0] i_mem_rdata,
  output logic o_mem_wr,
  // program counter control
  input wire mcuor_pkg::mcuor_pcop_e i_pc_op,
  input wire logic [9:0] i_target,
  input wire logic i_pc_add,
  input wire logic [7:0] i_acc,
  output logic [12:0] o_pc,
  // alu flags
  input wire logic i_flag_we,
  input wire logic [2:0] i_flags,
  // power events
  input wire logic i_sleep_cmd,
  input wire logic i_wdt_clear_cmd,
  input wire logic i_wdt_timeout,
  // timer source
  input wire logic i_timer_ext_sel,
  input wire logic i_timer_pin,
  // port and lcd outputs
  output logic [3:0] o_port5,
  output logic o_control_page_select,
  output logic [23:0] o_port678,
  output logic o_display_enable,
  output logic o_bias_select,
  output logic o_waveform_type,
  output logic [1:0] o_duty,
  output logic [9:0] o_frame_divisor,
  output logic [4:0] o_lcd_ram_pointer,
  output logic o_lcd_ground
);
  // registers
  logic [7:0] timer_count;
  logic [12:0] pc;
  logic [7:0] status_flags;
  logic [7:0] ram_bank_pointer;
  logic [7:0] port5_data_page;
  logic [7:0] port6_data, port7_data, port8_data;
  logic [7:0] lcd_control;
  logic [7:0] lcd_ram_pointer;
  logic [12:0] stack_mem [STACK_DEPTH];
  logic [$clog2(STACK_DEPTH)-1:0] sp;
  logic [7:0] rdata;
  // pin synchroniser and edge detect
  logic pin_s1, pin_s2, pin_s3;

  // indirect redirect of address 00h
  wire logic is_ind = (i_addr == mcuor_pkg::ADDR_INDIRECT);
  wire logic [5:0] eff_addr = is_ind ? ram_bank_pointer[5:0] : i_addr;
  wire logic hit_reg = (eff_addr <= mcuor_pkg::ADDR_LCD_PTR) && (eff_addr != 6'h00);
  wire logic wr_reg = i_wr && hit_reg;
  wire logic wr_tmr = wr_reg && (eff_addr == mcuor_pkg::ADDR_TIMER);
  wire logic wr_pc = wr_reg && (eff_addr == mcuor_pkg::ADDR_PC_LOW);
  wire logic wr_st = wr_reg && (eff_addr == mcuor_pkg::ADDR_STATUS);
  wire logic pin_edge = pin_s2 & ~pin_s3;
  wire logic tick = i_timer_ext_sel ? pin_edge : 1'b1;
  wire logic [1:0] page = status_flags[mcuor_pkg::ST_PAGE_HI:mcuor_pkg::ST_PAGE_LO];
  wire logic [12:0] pc_inc = pc + 13'h0001;
  wire logic [12:0] pc_added = pc + {5'h00, i_acc};
  wire logic [12:0] pc_moved = {1'b0, page, pc[9:8], i_wdata};
  wire logic [12:0] pc_jump = {1'b0, page, i_target};
  wire logic [12:0] stack_top = stack_mem[sp - 1'b1];
  wire logic [1:0] duty_code = lcd_control[mcuor_pkg::LCD_DUTY_HI] ? 2'h2 :
    {1'b0, lcd_control[mcuor_pkg::LCD_DUTY_LO]};
  // next lcd control value, so duty and ground outputs flop together with the register; frame divisor follows a cycle later
  wire logic wr_lcd = wr_reg && (eff_addr == mcuor_pkg::ADDR_LCD_CTRL);
  wire logic [7:0] next_lcd = wr_lcd ? (i_wdata & 8'hF7) : lcd_control;
  wire logic [1:0] next_duty = next_lcd[mcuor_pkg::LCD_DUTY_HI] ? 2'h2 :
    {1'b0, next_lcd[mcuor_pkg::LCD_DUTY_LO]};
  logic [9:0] next_div;

  // frame divisor lookup, per duty and rate code
  always_comb begin
    next_div = 10'h000;
    case ({duty_code, lcd_control[1:0]})
      4'h0: next_div = 10'h200;
      4'h1: next_div = 10'h230;
      4'h2: next_div = 10'h260;
      4'h3: next_div = 10'h1D0;
      4'h4: next_div = 10'h204;
      4'h5: next_div = 10'h234;
      4'h6: next_div = 10'h264;
      4'h7: next_div = 10'h1D4;
      4'h8: next_div = 10'h200;
      4'h9: next_div = 10'h230;
      4'hA: next_div = 10'h260;
      4'hB: next_div = 10'h1D0;
      default: next_div = 10'h200;
    endcase
  end

  // read mux
  always_comb begin
    rdata = 8'h00;
    case (eff_addr)
      mcuor_pkg::ADDR_TIMER: rdata = timer_count;
      mcuor_pkg::ADDR_PC_LOW: rdata = pc[7:0];
      mcuor_pkg::ADDR_STATUS: rdata = status_flags;
      mcuor_pkg::ADDR_RAM_PTR: rdata = ram_bank_pointer;
      mcuor_pkg::ADDR_PORT5: rdata = port5_data_page;
      mcuor_pkg::ADDR_PORT6: rdata = port6_data;
      mcuor_pkg::ADDR_PORT7: rdata = port7_data;
      mcuor_pkg::ADDR_PORT8: rdata = port8_data;
      mcuor_pkg::ADDR_LCD_CTRL: rdata = lcd_control;
      mcuor_pkg::ADDR_LCD_PTR: rdata = lcd_ram_pointer;
      default: rdata = i_mem_rdata; // general data memory
    endcase
  end

  // pin synchroniser
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= i_timer_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // timer counter, program write wins over counting
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timer_count <= mcuor_pkg::REG_RESET;
    end else if (wr_tmr) begin
      timer_count <= i_wdata;
    end else if (tick) begin
      timer_count <= timer_count + 8'h01;
    end
  end

  // program counter and stack
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc <= mcuor_pkg::PC_RESET;
      sp <= '0;
    end else if (i_pc_add) begin
      pc <= pc_added;
    end else if (wr_pc) begin
      pc <= pc_moved;
    end else begin
      case (i_pc_op)
        mcuor_pkg::MCUOR_PC_STEP: pc <= pc_inc;
        mcuor_pkg::MCUOR_PC_JUMP: pc <= pc_jump;
        mcuor_pkg::MCUOR_PC_CALL: begin
          stack_mem[sp] <= pc_inc;
          sp <= sp + 1'b1;
          pc <= pc_jump;
        end
        mcuor_pkg::MCUOR_PC_RET: begin
          pc <= stack_top;
          sp <= sp - 1'b1;
        end
        default: pc <= pc;
      endcase
    end
  end

  // status: page bits, power flags, alu flags; bit 7 reads zero
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_flags <= mcuor_pkg::STATUS_RESET;
    end else begin
      if (wr_st) begin
        status_flags[6:5] <= i_wdata[6:5];
        status_flags[2:0] <= i_wdata[2:0];
      end else if (i_flag_we) begin
        status_flags[2:0] <= i_flags;
      end
      if (i_wdt_timeout) begin
        status_flags[mcuor_pkg::ST_TIMEOUT] <= 1'b0;
      end else if (i_sleep_cmd) begin
        status_flags[mcuor_pkg::ST_TIMEOUT] <= 1'b1;
        status_flags[mcuor_pkg::ST_PWRDN] <= 1'b0;
      end else if (i_wdt_clear_cmd) begin
        status_flags[mcuor_pkg::ST_TIMEOUT] <= 1'b1;
        status_flags[mcuor_pkg::ST_PWRDN] <= 1'b1;
      end
    end
  end

  // plain read-write registers
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ram_bank_pointer <= mcuor_pkg::REG_RESET;
      port5_data_page <= mcuor_pkg::REG_RESET;
      port6_data <= mcuor_pkg::REG_RESET;
      port7_data <= mcuor_pkg::REG_RESET;
      port8_data <= mcuor_pkg::REG_RESET;
      lcd_control <= mcuor_pkg::REG_RESET;
      lcd_ram_pointer <= mcuor_pkg::REG_RESET;
    end else if (wr_reg) begin
      case (eff_addr)
        mcuor_pkg::ADDR_RAM_PTR: ram_bank_pointer <= i_wdata;
        mcuor_pkg::ADDR_PORT5: port5_data_page <= i_wdata & mcuor_pkg::PORT5_MASK;
        mcuor_pkg::ADDR_PORT6: port6_data <= i_wdata;
        mcuor_pkg::ADDR_PORT7: port7_data <= i_wdata;
        mcuor_pkg::ADDR_PORT8: port8_data <= i_wdata;
        mcuor_pkg::ADDR_LCD_CTRL: lcd_control <= i_wdata & 8'hF7;
        mcuor_pkg::ADDR_LCD_PTR: lcd_ram_pointer <= i_wdata & mcuor_pkg::LCD_PTR_MASK;
        default: lcd_ram_pointer <= lcd_ram_pointer;
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
      o_mem_addr <= 6'h00;
      o_mem_wr <= 1'b0;
      o_frame_divisor <= 10'h000;
      o_duty <= 2'h0;
      o_lcd_ground <= 1'b1;
    end else begin
      o_rdata <= rdata;
      o_mem_addr <= eff_addr;
      o_mem_wr <= i_wr && !hit_reg;
      o_frame_divisor <= next_div;
      o_duty <= next_duty;
      o_lcd_ground <= ~next_lcd[mcuor_pkg::LCD_EN];
    end
  end

  // these mirror registers directly
  assign o_pc = pc;
  assign o_port5 = port5_data_page[7:4];
  assign o_control_page_select = port5_data_page[0];
  assign o_port678 = {port8_data, port7_data, port6_data};
  assign o_display_enable = lcd_control[mcuor_pkg::LCD_EN];
  assign o_bias_select = lcd_control[mcuor_pkg::LCD_BIAS];
  assign o_waveform_type = lcd_control[mcuor_pkg::LCD_WAVE];
  assign o_lcd_ram_pointer = lcd_ram_pointer[4:0];

  // checks
  property p_pc_reset;
    @(posedge i_clock) $rose(i_rst_b) |-> (pc == 13'h0000);
  endproperty
  a_pc_reset: assert property (p_pc_reset) else $error("pc not zero after reset");
  property p_jump;
    @(posedge i_clock) disable iff (!i_rst_b)
      (i_pc_op == mcuor_pkg::MCUOR_PC_JUMP && !i_pc_add && !wr_pc)
      |=> pc == {1'b0, $past(page), $past(i_target)};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");
  property p_ret;
    @(posedge i_clock) disable iff (!i_rst_b)
      (i_pc_op == mcuor_pkg::MCUOR_PC_RET && !i_pc_add && !wr_pc)
      |=> pc == $past(stack_top);
  endproperty
  a_ret: assert property (p_ret) else $error("return address wrong");
  property p_move;
    @(posedge i_clock) disable iff (!i_rst_b)
      (wr_pc && !i_pc_add) |=> pc[11:0] == {$past(page), $past(pc[9:8]), $past(i_wdata)};
  endproperty
  a_move: assert property (p_move) else $error("move to pc wrong");
  property p_sleep;
    @(posedge i_clock) disable iff (!i_rst_b)
      (i_sleep_cmd && !i_wdt_timeout) |=> status_flags[4:3] == 2'b10;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
  property p_wdt;
    @(posedge i_clock) disable iff (!i_rst_b)
      i_wdt_timeout |=> !status_flags[4];
  endproperty
  a_wdt: assert property (p_wdt) else $error("timeout flag not cleared");
  property p_lcdptr;
    @(posedge i_clock) disable iff (!i_rst_b) lcd_ram_pointer[7:5] == 3'h0;
  endproperty
  a_lcdptr: assert property (p_lcdptr) else $error("lcd pointer high bits set");
  property p_timer;
    @(posedge i_clock) disable iff (!i_rst_b)
      (!wr_tmr && !i_timer_ext_sel) |=> timer_count == $past(timer_count) + 8'h01;
  endproperty
  a_timer: assert property (p_timer) else $error("timer did not count");
  // a call request that no add or move overrides
  sequence s_call_req;
    (i_pc_op == mcuor_pkg::MCUOR_PC_CALL) && !i_pc_add && !wr_pc;
  endsequence
  property p_call;
    @(posedge i_clock) disable iff (!i_rst_b)
      s_call_req |=> (stack_top == $past(pc) + 13'h0001) && (pc[9:0] == $past(i_target));
  endproperty
  a_call: assert property (p_call) else $error("call push or target wrong");
  property p_add;
    @(posedge i_clock) disable iff (!i_rst_b)
      i_pc_add |=> pc == $past(pc) + {5'h00, $past(i_acc)};
  endproperty
  a_add: assert property (p_add) else $error("add to pc wrong");
  property p_clear;
    @(posedge i_clock) disable iff (!i_rst_b)
      (i_wdt_clear_cmd && !i_sleep_cmd && !i_wdt_timeout) |=> status_flags[4:3] == 2'b11;
  endproperty
  a_clear: assert property (p_clear) else $error("watchdog clear flags wrong");
  property p_ground;
    @(posedge i_clock) disable iff (!i_rst_b) o_lcd_ground == !o_display_enable;
  endproperty
  a_ground: assert property (p_ground) else $error("lcd ground not inverse of enable");
  property p_redirect;
    @(posedge i_clock) disable iff (!i_rst_b)
      (i_wr && is_ind && !hit_reg) |=> o_mem_wr && ({2'h0, o_mem_addr} == ($past(ram_bank_pointer) & 8'h3F));
  endproperty
  a_redirect: assert property (p_redirect) else $error("indirect write address wrong");
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Purpose: self-checking bench for the operational register bank
// Assumes: inputs change on the falling edge, results sampled one falling edge later
// Notes: general memory is modelled as data {2'b10, address}
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // clock, reset and bookkeeping
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  // register port stimulus
  logic [5:0] i_addr = 6'h00;
  logic i_wr = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic [5:0] o_mem_addr;
  logic o_mem_wr;
  wire logic [7:0] i_mem_rdata;
  // program counter and event stimulus
  mcuor_pkg::mcuor_pcop_e i_pc_op = mcuor_pkg::MCUOR_PC_HOLD;
  logic [9:0] i_target = 10'h000;
  logic i_pc_add = 1'b0;
  logic [7:0] i_acc = 8'h00;
  logic [12:0] o_pc;
  logic i_flag_we = 1'b0;
  logic [2:0] i_flags = 3'h0;
  logic i_sleep_cmd = 1'b0;
  logic i_wdt_clear_cmd = 1'b0;
  logic i_wdt_timeout = 1'b0;
  logic i_timer_ext_sel = 1'b1;
  logic i_timer_pin = 1'b0;
  // observed outputs
  logic [3:0] o_port5;
  logic o_control_page_select;
  logic [23:0] o_port678;
  logic o_display_enable;
  logic o_bias_select;
  logic o_waveform_type;
  logic [1:0] o_duty;
  logic [9:0] o_frame_divisor;
  logic [4:0] o_lcd_ram_pointer;
  logic o_lcd_ground;
  // frame divisor bases and event table {clear, sleep, timeout} with flag pairs
  localparam int BASE [12] = '{256, 280, 304, 232, 172, 188, 204, 156, 128, 140, 152, 116};
  localparam logic [2:0] EV [4] = '{3'h1, 3'h2, 3'h1, 3'h4};
  localparam logic [1:0] TP [4] = '{2'h1, 2'h2, 2'h0, 2'h3};

  // memory answers with its own address so redirection is visible
  assign i_mem_rdata = {2'h2, o_mem_addr};

  // free-running clock, 4 ns period
  always #2 i_clock = ~i_clock;

  // hang guard
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      end_of_test();
    end
  end

  mcuor_regs dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr(i_wr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_mem_addr(o_mem_addr), .i_mem_rdata(i_mem_rdata),
    .o_mem_wr(o_mem_wr), .i_pc_op(i_pc_op), .i_target(i_target), .i_pc_add(i_pc_add),
    .i_acc(i_acc), .o_pc(o_pc), .i_flag_we(i_flag_we), .i_flags(i_flags),
    .i_sleep_cmd(i_sleep_cmd), .i_wdt_clear_cmd(i_wdt_clear_cmd),
    .i_wdt_timeout(i_wdt_timeout), .i_timer_ext_sel(i_timer_ext_sel),
    .i_timer_pin(i_timer_pin), .o_port5(o_port5), .o_control_page_select(o_control_page_select),
    .o_port678(o_port678), .o_display_enable(o_display_enable), .o_bias_select(o_bias_select),
    .o_waveform_type(o_waveform_type), .o_duty(o_duty), .o_frame_divisor(o_frame_divisor),
    .o_lcd_ram_pointer(o_lcd_ram_pointer), .o_lcd_ground(o_lcd_ground));

  // verdict and end of run
  task automatic end_of_test();
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // compare of any design value, zero extended
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: value %0h expected %0h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge i_clock);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_clock);
    i_wr = 1'b0;
  endtask

  // read, data registered one cycle after the address
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(negedge i_clock);
    i_addr = a;
    @(negedge i_clock);
    v = o_rdata;
  endtask

  // read and compare
  task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  // one program counter operation, then hold
  task automatic pcop(input mcuor_pkg::mcuor_pcop_e op, input logic [9:0] t, input logic add);
    @(negedge i_clock);
    i_pc_op = op;
    i_target = t;
    i_pc_add = add;
    @(negedge i_clock);
    i_pc_op = mcuor_pkg::MCUOR_PC_HOLD;
    i_pc_add = 1'b0;
  endtask

  // main sequence
  initial begin
    logic [7:0] v;
    logic [7:0] r1;
    logic [7:0] lv;
    int d;
    repeat (8) @(negedge i_clock);
    i_rst_b = 1'b1;
    chk(o_pc, 24'h0);
    // reset values of 01h..0Ah
    for (int a = 1; a <= 10; a++) rdc(6'(a), (a == 3) ? 8'h18 : 8'h00);
    // power event flag pairs
    for (int k = 0; k < 4; k++) begin
      @(negedge i_clock);
      {i_wdt_clear_cmd, i_sleep_cmd, i_wdt_timeout} = EV[k];
      @(negedge i_clock);
      {i_wdt_clear_cmd, i_sleep_cmd, i_wdt_timeout} = 3'h0;
      rdc(mcuor_pkg::ADDR_STATUS, {3'h0, TP[k], 3'h0});
    end
    // status write masks flags, alu load of low bits
    wr(mcuor_pkg::ADDR_STATUS, 8'hE7);
    rdc(mcuor_pkg::ADDR_STATUS, 8'h7F);
    @(negedge i_clock);
    i_flag_we = 1'b1;
    i_flags = 3'h2;
    @(negedge i_clock);
    i_flag_we = 1'b0;
    rdc(mcuor_pkg::ADDR_STATUS, 8'h7A);
    // jump in page 3, call in page 1, step, return
    pcop(mcuor_pkg::MCUOR_PC_JUMP, 10'h155, 1'b0);
    chk(o_pc, 24'hD55);
    wr(mcuor_pkg::ADDR_STATUS, 8'h20);
    pcop(mcuor_pkg::MCUOR_PC_CALL, 10'h0AA, 1'b0);
    chk(o_pc, 24'h4AA);
    pcop(mcuor_pkg::MCUOR_PC_STEP, 10'h000, 1'b0);
    chk(o_pc, 24'h4AB);
    pcop(mcuor_pkg::MCUOR_PC_RET, 10'h000, 1'b0);
    chk(o_pc, 24'hD56);
    rdc(mcuor_pkg::ADDR_STATUS, 8'h38);
    // move replaces low eight, add carries upward
    wr(mcuor_pkg::ADDR_PC_LOW, 8'h34);
    @(negedge i_clock);
    chk(o_pc, 24'h534);
    rdc(mcuor_pkg::ADDR_PC_LOW, 8'h34);
    i_acc = 8'hF0;
    pcop(mcuor_pkg::MCUOR_PC_HOLD, 10'h000, 1'b1);
    chk(o_pc, 24'h624);
    // timer on pin edges, then on every cycle
    wr(mcuor_pkg::ADDR_TIMER, 8'h10);
    rdc(mcuor_pkg::ADDR_TIMER, 8'h10);
    repeat (3) begin
      @(negedge i_clock);
      i_timer_pin = 1'b1;
      repeat (3) @(negedge i_clock);
      i_timer_pin = 1'b0;
      repeat (3) @(negedge i_clock);
    end
    rdc(mcuor_pkg::ADDR_TIMER, 8'h13);
    i_timer_ext_sel = 1'b0;
    rd(mcuor_pkg::ADDR_TIMER, r1);
    rd(mcuor_pkg::ADDR_TIMER, v);
    chk(8'(v - r1), 24'h2);
    // ports, port5 mask and page select
    wr(mcuor_pkg::ADDR_PORT5, 8'hFF);
    rdc(mcuor_pkg::ADDR_PORT5, 8'hF1);
    chk({o_port5, o_control_page_select}, 24'h1F);
    wr(mcuor_pkg::ADDR_PORT6, 8'h5A);
    wr(mcuor_pkg::ADDR_PORT7, 8'hA5);
    wr(mcuor_pkg::ADDR_PORT8, 8'h3C);
    chk(o_port678, 24'h3CA55A);
    // indirect window to a port and to general memory
    wr(mcuor_pkg::ADDR_RAM_PTR, 8'hC7);
    rdc(mcuor_pkg::ADDR_RAM_PTR, 8'hC7);
    wr(mcuor_pkg::ADDR_INDIRECT, 8'h81);
    chk(o_port678, 24'h3C815A);
    rdc(mcuor_pkg::ADDR_INDIRECT, 8'h81);
    wr(mcuor_pkg::ADDR_RAM_PTR, 8'h15);
    @(negedge i_clock);
    i_addr = mcuor_pkg::ADDR_INDIRECT;
    i_wr = 1'b1;
    @(negedge i_clock);
    i_wr = 1'b0;
    chk({o_mem_wr, o_mem_addr}, 24'h55);
    rdc(mcuor_pkg::ADDR_INDIRECT, 8'h95);
    // lcd control, every duty and rate code
    for (int c = 0; c < 16; c++) begin
      lv = {c[0], c[3:2], c[2], 1'b1, c[1], c[1:0]};
      d = c[3] ? 2 : int'(c[2]);
      wr(mcuor_pkg::ADDR_LCD_CTRL, lv);
      @(negedge i_clock);
      chk(o_frame_divisor, 24'(BASE[d * 4 + c[1:0]] * (d + 2)));
      chk({o_bias_select, o_duty, o_display_enable, o_lcd_ground, o_waveform_type},
        {c[0], 2'(d), c[2], ~c[2], c[1]});
      rdc(mcuor_pkg::ADDR_LCD_CTRL, lv & 8'hF7);
    end
    // lcd pointer upper bits read zero
    wr(mcuor_pkg::ADDR_LCD_PTR, 8'hFF);
    rdc(mcuor_pkg::ADDR_LCD_PTR, 8'h1F);
    chk(o_lcd_ram_pointer, 24'h1F);
    // second reset mid-run clears the counter again
    @(negedge i_clock);
    i_rst_b = 1'b0;
    @(negedge i_clock);
    i_rst_b = 1'b1;
    chk(o_pc, 24'h0);
    rdc(mcuor_pkg::ADDR_STATUS, 8'h18);
    end_of_test();
  end
endmodule
`default_nettype wire
